// >>> status_pkg.sv
package status_pkg;
  // Register byte offsets on the APB window
  localparam logic [11:0] ADDR_STATUS    = 12'h000;  // Status word, read only
  localparam logic [11:0] ADDR_CONTROL   = 12'h004;  // Control word copy
  localparam logic [11:0] ADDR_RETENTION = 12'h008;  // Homing retention setting
  // Status word bit positions
  localparam int BIT_NO_ENABLE = 6;   // Servo cannot be enabled
  localparam int BIT_ALARM     = 7;   // Fault active
  localparam int BIT_RSVD_A    = 8;   // Reserved, reads zero
  localparam int BIT_REMOTE    = 9;   // Control word obeyed
  localparam int BIT_ARRIVED   = 10;  // Target reached or stopped
  localparam int BIT_SOFT_LIM  = 11;  // Soft limit reached
  localparam int BIT_IP_MODE   = 12;  // Interpolated position active
  localparam int BIT_RSVD_B    = 13;  // Reserved, reads zero
  localparam int BIT_RSVD_C    = 14;  // Reserved, reads zero
  localparam int BIT_HOMED     = 15;  // Homing completed
  // Control word pause bit
  localparam int CTL_PAUSE = 8;
  // Retention digit: second hex digit from the right
  localparam int           RET_DIGIT_LSB = 4;
  localparam logic [3:0]   RET_KEEP      = 4'h2;
  // Reset values
  localparam logic [15:0]  CONTROL_RST   = 16'h0000;
  localparam logic [15:0]  RETENTION_RST = 16'h0000;
  localparam logic [15:0]  STATUS_RST    = 16'h0000;
  localparam logic [31:0]  RDATA_ZERO    = 32'h0000_0000;
endpackage : status_pkg

// >>> homing_if.sv
`timescale 1ns/1ps
interface homing_if;
  logic set_done;   // Homing finished successfully, pulse
  logic start;      // New homing started, pulse
  logic disabled;   // Drive cannot be enabled, level
  logic retain;     // Keep flag through disable, level
  logic done;       // Stored homing-done flag
  modport ctrl  (output set_done, start, disabled, retain, input done);
  modport store (input set_done, start, disabled, retain, output done);
endinterface : homing_if

// >>> homing_store.sv
`timescale 1ns/1ps
module homing_store (
  input  wire logic  clk_sys,  // Control clock
  input  wire logic  rst_n,    // Sync reset, active low
  input  wire logic  ce,       // Clock enable
  homing_if.store    hs        // Homing flag signals
);
  logic done;       // Stored flag
  logic next_done;  // Next value

  // Set wins over any clear in the same cycle
  always_comb begin
    next_done = done;
    if (hs.start || (hs.disabled && !hs.retain)) begin
      next_done = 1'b0;  // Without retention a disable forgets homing
    end
    if (hs.set_done) begin
      next_done = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= next_done;
    end
  end

  assign hs.done = done;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_HOMED_SET: assert property (ce && hs.set_done |=> done)
    else $error("Homing flag not set after success");
  AST_HOMED_KEPT: assert property (done && ce && hs.retain && !hs.start && !hs.set_done |=> done)
    else $error("Retained homing flag lost");
endmodule : homing_store

// >>> servo_status_word.sv
`timescale 1ns/1ps
// Operation
// - Bit 7 follows active drive fault
// - Bits 8, 13, 14 always read zero
// - Bit 9 set while control word obeyed
// - Pause clear: bit 10 means target reached
// - Pause set: bit 10 means speed zero
// - Bit 11 follows soft limit reached
// - Bit 12 shows interpolated mode active
// - Bit 15 homing done, retained on setting with an absolute encoder fitted
// - Bit 6 set while enabling impossible
module servo_status_word (
  input  wire logic        clk_sys,         // Control clock, 25 MHz
  input  wire logic        rst_n,           // Sync reset, active low
  input  wire logic        ce,              // Clock enable, freezes state
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB write
  input  wire logic [11:0] paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error, unmapped address
  input  wire logic        fault_active,    // Any drive fault present
  input  wire logic        cw_obeyed,       // Control word being obeyed
  input  wire logic        target_reached,  // Commanded position reached
  input  wire logic        speed_zero,      // Motor speed is zero
  input  wire logic        soft_limit_hit,  // Software limit reached
  input  wire logic        ip_mode_active,  // Interpolated mode running
  input  wire logic        cannot_enable,   // Servo cannot be enabled
  input  wire logic        abs_encoder,     // Absolute encoder fitted
  input  wire logic        homing_start,    // Homing begins, pulse
  input  wire logic        homing_ok,       // Homing succeeded, pulse
  output logic      [15:0] status_word,     // Composed status word
  output logic      [15:0] control_word     // Control word as written
);
  // Local register state
  logic [15:0] retention;       // Homing retention setting
  logic [15:0] next_status;     // Next status word
  logic [15:0] next_control;    // Next control word
  logic [15:0] next_retention;  // Next retention setting
  logic [31:0] next_prdata;     // Next read data
  logic        next_pready;     // Next ready
  logic        next_pslverr;    // Next error

  homing_if hif ();             // Homing flag carrier

  // Address decode, used only for the bus error flag
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == status_pkg::ADDR_STATUS) || (a == status_pkg::ADDR_CONTROL)
          || (a == status_pkg::ADDR_RETENTION);
  endfunction : mapped

  // Write happens only on the completing access edge
  function automatic logic wr_hit(input logic [11:0] a);
    wr_hit = psel && penable && pready && pwrite && (paddr == a);
  endfunction : wr_hit

  // Homing storage, retention only for absolute systems
  assign hif.set_done = homing_ok;
  assign hif.start    = homing_start;
  assign hif.disabled = cannot_enable;
  assign hif.retain   = abs_encoder
    && (retention[status_pkg::RET_DIGIT_LSB +: 4] == status_pkg::RET_KEEP);

  homing_store u_homing (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .hs      (hif.ctrl)
  );

  // Status word composed from live state each cycle
  always_comb begin
    next_status = status_pkg::STATUS_RST;  // Low bits belong elsewhere
    next_status[status_pkg::BIT_NO_ENABLE] = cannot_enable;
    next_status[status_pkg::BIT_ALARM]     = fault_active;
    next_status[status_pkg::BIT_REMOTE]    = cw_obeyed;
    // Pause selects which meaning bit 10 carries
    if (control_word[status_pkg::CTL_PAUSE]) begin
      next_status[status_pkg::BIT_ARRIVED] = speed_zero;
    end else begin
      next_status[status_pkg::BIT_ARRIVED] = target_reached;
    end
    next_status[status_pkg::BIT_SOFT_LIM]  = soft_limit_hit;
    next_status[status_pkg::BIT_IP_MODE]   = ip_mode_active;
    next_status[status_pkg::BIT_HOMED]     = hif.done;
    // Reserved bits carry no function
    next_status[status_pkg::BIT_RSVD_A]    = 1'b0;
    next_status[status_pkg::BIT_RSVD_B]    = 1'b0;
    next_status[status_pkg::BIT_RSVD_C]    = 1'b0;
  end

  // Status register, never written by the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_word <= status_pkg::STATUS_RST;
    end else if (ce) begin
      status_word <= next_status;
    end
  end

  // Writable registers; status writes are dropped
  always_comb begin
    next_control   = control_word;
    next_retention = retention;
    if (wr_hit(status_pkg::ADDR_CONTROL)) begin
      next_control = pwdata[15:0];
    end
    if (wr_hit(status_pkg::ADDR_RETENTION)) begin
      next_retention = pwdata[15:0];
    end
  end

  // Register stage for writable state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_word <= status_pkg::CONTROL_RST;
      retention    <= status_pkg::RETENTION_RST;
    end else if (ce) begin
      control_word <= next_control;
      retention    <= next_retention;
    end
  end

  // APB answer: one wait state, data registered with ready
  always_comb begin
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = status_pkg::RDATA_ZERO;
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !mapped(paddr);
      if (!pwrite) begin
        case (paddr)
          status_pkg::ADDR_STATUS:    next_prdata[15:0] = status_word;
          status_pkg::ADDR_CONTROL:   next_prdata[15:0] = control_word;
          status_pkg::ADDR_RETENTION: next_prdata[15:0] = retention;
          default:                    next_prdata = status_pkg::RDATA_ZERO;
        endcase
      end
    end
  end

  // Register stage for the bus answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= status_pkg::RDATA_ZERO;
    end else if (ce) begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // Checks on the composed word; ce low freezes it, so each check waits for ce except the reserved-bit, error and upper-data ones
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Fault and alarm bit track each other one cycle apart
  AST_ALARM: assert property (ce && fault_active |=> status_word[status_pkg::BIT_ALARM])
    else $error("Alarm bit missing while fault active");
  AST_NO_ALARM: assert property (ce && !fault_active |=> !status_word[status_pkg::BIT_ALARM])
    else $error("Alarm bit set without fault");

  // Reserved bits hold zero at all times, not only after a cycle
  AST_RESERVED: assert property (!status_word[status_pkg::BIT_RSVD_A]
                                 && !status_word[status_pkg::BIT_RSVD_B]
                                 && !status_word[status_pkg::BIT_RSVD_C])
    else $error("Reserved status bit nonzero");

  // Remote bit follows whether the control word is obeyed
  AST_REMOTE: assert property (ce |=> status_word[status_pkg::BIT_REMOTE] == $past(cw_obeyed))
    else $error("Remote bit does not follow control state");

  // Stored pause bit picks the meaning of the arrival bit
  AST_ARRIVE_RUN: assert property (ce && !control_word[status_pkg::CTL_PAUSE]
                                   |=> status_word[status_pkg::BIT_ARRIVED] == $past(target_reached))
    else $error("Arrival bit wrong with pause clear");
  AST_ARRIVE_PAUSE: assert property (ce && control_word[status_pkg::CTL_PAUSE]
                                     |=> status_word[status_pkg::BIT_ARRIVED] == $past(speed_zero))
    else $error("Arrival bit wrong with pause set");

  // Soft limit and interpolation bits are plain level copies
  AST_SOFT_LIMIT: assert property (ce |=> status_word[status_pkg::BIT_SOFT_LIM] == $past(soft_limit_hit))
    else $error("Soft limit bit stale");
  AST_IP_MODE: assert property (ce |=> status_word[status_pkg::BIT_IP_MODE] == $past(ip_mode_active))
    else $error("Interpolation bit stale");

  // Homing bit shows two cycles after success: store, then word
  AST_HOMED: assert property (ce && homing_ok ##1 ce |=> status_word[status_pkg::BIT_HOMED])
    else $error("Homing bit not shown after success");

  // Enable-blocked bit follows its input
  AST_NO_ENABLE: assert property (ce |=> status_word[status_pkg::BIT_NO_ENABLE] == $past(cannot_enable))
    else $error("Enable-blocked bit stale");

  // A write aimed at the status word must not reach it
  AST_RO_STATUS: assert property (ce && psel && penable && pready && pwrite
                                  && paddr == status_pkg::ADDR_STATUS && !fault_active
                                  |=> !status_word[status_pkg::BIT_ALARM])
    else $error("Status word changed by a write");

  // Bus answer lasts one cycle, so no transfer completes twice
  AST_READY_PULSE: assert property (ce && pready |=> !pready)
    else $error("Ready held longer than one cycle");

  // Error only ever rides on a ready
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("Error flag without ready");

  // Status writes are dropped quietly, not refused
  AST_STATUS_WR_OK: assert property (ce && psel && penable && !pready && pwrite
                                     && paddr == status_pkg::ADDR_STATUS |=> pready && !pslverr)
    else $error("Status write answered with an error");

  // Status read returns the word as it stood at the access edge
  AST_STATUS_RD: assert property (ce && psel && penable && !pready && !pwrite
                                  && paddr == status_pkg::ADDR_STATUS |=> prdata[15:0] == $past(status_word))
    else $error("Status read data differs from the word");

  // Upper read data half is always zero
  AST_RDATA_UPPER: assert property (prdata[31:16] == status_pkg::RDATA_ZERO[31:16])
    else $error("Upper read data bits nonzero");
endmodule : servo_status_word

// >>> bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic        clk_sys,  // Control clock
  output logic             psel,     // APB select
  output logic             penable,  // APB access phase
  output logic             pwrite,   // APB direction
  output logic      [11:0] paddr,    // APB byte address
  output logic      [31:0] pwdata,   // APB write data
  input  wire logic [31:0] prdata,   // APB read data
  input  wire logic        pready,   // APB ready
  input  wire logic        pslverr   // APB error
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // One transfer; held until pready seen high, no wait limit of its own
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show inverted data, so stale values never look valid
    paddr   <= ~addr;
    pwdata  <= ~wd;
  endtask : xfer
endmodule : bus_master_model

// >>> servo_status_word_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module servo_status_word_tb;
  logic        clk_sys;                // Control clock
  logic        rst_n;                  // Sync reset
  logic        psel, penable, pwrite;  // APB request
  logic [11:0] paddr;                  // APB address
  logic [31:0] pwdata, prdata, rd;     // APB data, last read
  logic        pready, pslverr, err;   // APB answer, last error
  logic [6:0]  lv;                     // Level inputs
  logic [1:0]  hv;                     // Homing pulses: start, ok
  logic        abs_enc;                // Absolute encoder fitted
  logic        ce;                     // Clock enable to the design
  logic [15:0] status_word, control_word;
  int          mismatches, compares, cycles;
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  initial begin
    rst_n = 1'b0; lv = 7'h00; hv = 2'b00; abs_enc = 1'b0; ce = 1'b1;
    mismatches = 0; compares = 0; cycles = 0;
  end
  servo_status_word servo_status_word_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_active(lv[0]), .cw_obeyed(lv[1]),
    .target_reached(lv[2]), .speed_zero(lv[3]), .soft_limit_hit(lv[4]), .ip_mode_active(lv[5]),
    .cannot_enable(lv[6]), .abs_encoder(abs_enc), .homing_start(hv[1]), .homing_ok(hv[0]),
    .status_word(status_word), .control_word(control_word));
  bus_master_model bus_master_model_i (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus_master_model_i.xfer(1'b1, a, d, rd, err);
    // Registers update on the completing edge; look once they have settled
    @(negedge clk_sys);
  endtask : wr
  // Status read over the bus, checked against the port too
  task automatic chk_status(input logic [15:0] exp);
    bus_master_model_i.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
    @(negedge clk_sys);
    `CHK("status read", {16'h0000, exp}, rd)
    `CHK("status port", exp, status_word)
  endtask : chk_status
  task automatic drive(input logic [6:0] v);
    @(posedge clk_sys);
    lv <= v;
  endtask : drive
  task automatic pulse(input logic [1:0] p);
    @(posedge clk_sys);
    hv <= p;
    @(posedge clk_sys);
    hv <= 2'b00;
  endtask : pulse
  task automatic t_flags();
    logic [15:0] exp [7];
    exp = '{16'h0080, 16'h0200, 16'h0400, 16'h0000, 16'h0800, 16'h1000, 16'h0040};
    chk_status(16'h0000);
    for (int i = 0; i < 7; i++) begin
      drive(7'h01 << i);
      chk_status(exp[i]);
    end
    drive(7'h7F);
    chk_status(16'h1EC0);
    drive(7'h00);
    $display("test flags done");
  endtask : t_flags
  // Clock enable low must freeze the composed word
  task automatic t_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    lv <= 7'h01;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("frozen status", 16'h0000, status_word)
    @(posedge clk_sys);
    ce <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("thawed status", 16'h0080, status_word)
    drive(7'h00);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_pause();
    wr(12'h004, 32'h0000_0100);
    `CHK("control port", 16'h0100, control_word)
    bus_master_model_i.xfer(1'b0, 12'h004, 32'h0000_0000, rd, err);
    `CHK("control read", 32'h0000_0100, rd)
    drive(7'h04);
    chk_status(16'h0000);
    drive(7'h08);
    chk_status(16'h0400);
    wr(12'h004, 32'h0000_0000);
    drive(7'h00);
    $display("test pause done");
  endtask : t_pause
  task automatic t_access();
    wr(12'h000, 32'hFFFF_FFFF);
    `CHK("status write error", 1'b0, err)
    chk_status(16'h0000);
    wr(12'h00C, 32'h0000_0100);
    `CHK("unmapped error", 1'b1, err)
    `CHK("control kept", 16'h0000, control_word)
    bus_master_model_i.xfer(1'b0, 12'h00C, 32'h0000_0000, rd, err);
    `CHK("unmapped read data", 32'h0000_0000, rd)
    `CHK("unmapped read error", 1'b1, err)
    $display("test access done");
  endtask : t_access
  task automatic t_homing();
    pulse(2'b01);
    chk_status(16'h8000);
    drive(7'h40);
    chk_status(16'h0040);
    drive(7'h00);
    wr(12'h008, 32'h0000_0020);
    bus_master_model_i.xfer(1'b0, 12'h008, 32'h0000_0000, rd, err);
    `CHK("retention read", 32'h0000_0020, rd)
    // Setting alone, with no absolute encoder, keeps nothing
    pulse(2'b01);
    drive(7'h40);
    chk_status(16'h0040);
    drive(7'h00);
    @(posedge clk_sys);
    abs_enc <= 1'b1;
    pulse(2'b01);
    drive(7'h40);
    chk_status(16'h8040);
    pulse(2'b10);
    chk_status(16'h0040);
    // Success and restart in one cycle: success wins
    pulse(2'b11);
    chk_status(16'h8040);
    $display("test homing done");
  endtask : t_homing
  // Mid-run reset clears the word, the control copy and the homing flag
  task automatic t_reset();
    drive(7'h00);
    pulse(2'b01);
    wr(12'h004, 32'h0000_0100);
    chk_status(16'h8000);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    `CHK("reset status", 16'h0000, status_word)
    `CHK("reset control", 16'h0000, control_word)
    chk_status(16'h0000);
    $display("test reset done");
  endtask : t_reset
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_flags();
    t_freeze();
    t_pause();
    t_access();
    t_homing();
    t_reset();
    conclude();
  end
endmodule : servo_status_word_tb
